/* src/clk_divider.sv */
/*
  Clock-enable style divider: emits a one-cycle tick every n source cycles.
  Assumes the divisor may change at any time; a change restarts the count.
*/
`timescale 1ns/1ps
module clk_divider #(
  parameter int W = 8
) (
  input  wire logic         i_mclk,    // System clock
  input  wire logic         i_sys_rst, // Synchronous reset, active high
  input  wire logic [W-1:0] i_div,     // Divisor, 0 and 1 mean divide-by-one
  output logic              o_tick     // One pulse per divided period
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic [W-1:0] div;
    logic         tick;
  } div_state_t;

  div_state_t st_q;
  div_state_t st_d;

  always_comb begin
    st_d     = st_q;
    st_d.div = i_div;
    if (i_div != st_q.div || i_div <= W'(1)) begin
      // Divide-by-one passes every cycle; a new divisor restarts cleanly
      st_d.cnt  = '0;
      st_d.tick = (i_div <= W'(1));
    end else if (st_q.cnt >= i_div - W'(1)) begin
      st_d.cnt  = '0;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt  = st_q.cnt + W'(1);
      st_d.tick = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_tick = st_q.tick;
endmodule

/* src/sys_clock_gate_divider_mux.sv */
/*
  System clock-control register block: peripheral clock gates, nine
  programmable dividers, receive bit-clock source select, boot-image strap,
  protection range and connector function selects.
  Assumes a plain register port on the system clock and synchronous strap pin.
// Summary of operation
// - Set gate bit enables clock; reset all enabled
// - Gate bits: audio, USB, flash, ctrl, voltage, power, bootspi, card
// - Transmit divisor 8 bits; 0,1 divide-by-one
// - Receive divisor independent, same encoding
// - Source select: 0 receive, 1 transmit divider
// - Card reference divisor in low byte
// - Three debounce divisors, top byte zero
// - Three SPI master divisors, reset zero
// - Protection range 16 bits, resets zero
// - Connector bits select peripheral or GPIO
*/
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module sys_clock_gate_divider_mux (
  input  wire logic                          i_mclk,          // System clock, 50 MHz
  input  wire logic                          i_sys_rst,       // Synchronous reset, high
  input  wire logic [sysclk_pkg::ADDR_W-1:0] i_addr,          // Register byte offset
  input  wire logic [31:0]                   i_wdata,         // Write data
  input  wire logic                          i_wr,            // Write strobe
  input  wire logic                          i_rd,            // Read strobe
  input  wire logic                          i_image_strap,   // Boot-image strap pin
  output logic      [31:0]                   o_rdata,         // Read data, cycle after i_rd
  output logic      [7:0]                    o_clk_gate_en,   // Per-peripheral clock enables
  output logic                               o_tx_bitclk_tick, // Transmit bit-clock tick
  output logic                               o_rx_bitclk_tick, // Selected receive tick
  output logic                               o_card_refclk_tick, // Card ref clock tick
  output logic      [2:0]                    o_debounce_tick, // Debounce clock ticks
  output logic      [2:0]                    o_spi_master_tick, // SPI master clock ticks
  output logic      [15:0]                   o_protect_window, // Protection range value
  output logic      [2:0]                    o_connector_gpio // 1 = connector in GPIO mode
);
  typedef struct packed {
    sysclk_pkg::cfg_t cfg;
    logic             strap;
    logic [31:0]      rdata;
  } top_state_t;

  top_state_t st_q;
  top_state_t st_d;
  logic [8:0] ticks;
  logic [7:0] div_sel [sysclk_pkg::DIV_COUNT];

  function automatic logic [31:0] read_word(input top_state_t s, input logic [7:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      sysclk_pkg::OFF_CLOCK_GATES:  r = {24'h00_0000, s.cfg.gates};
      sysclk_pkg::OFF_TX_DIV:       r = {24'h00_0000, s.cfg.tx_div};
      sysclk_pkg::OFF_RX_DIV:       r = {24'h00_0000, s.cfg.rx_div};
      sysclk_pkg::OFF_RX_SRC:       r = {31'h0000_0000, s.cfg.rx_src};
      sysclk_pkg::OFF_CARD_DIV:     r = {24'h00_0000, s.cfg.card_div};
      sysclk_pkg::OFF_DEBOUNCE_DIV: r = {8'h00, s.cfg.deb2_div, s.cfg.deb1_div,
                                         s.cfg.deb0_div};
      sysclk_pkg::OFF_SPI_DIV:      r = {8'h00, s.cfg.spi2_div, s.cfg.spi1_div,
                                         s.cfg.spi0_div};
      sysclk_pkg::OFF_BOOT_IMAGE:   r[sysclk_pkg::BOOT_IMAGE_BIT] = s.strap;
      sysclk_pkg::OFF_PROTECT:      r = {16'h0000, s.cfg.protect};
      sysclk_pkg::OFF_CONNECTOR:    r = {29'h0000_0000, s.cfg.connector};
      default:                      r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_comb begin
    st_d       = st_q;
    // Strap sampled every cycle so a late-settling pin is seen, not latched once
    st_d.strap = i_image_strap;
    st_d.rdata = 32'h0000_0000;
    if (i_rd) begin
      st_d.rdata = read_word(st_q, i_addr);
    end
    if (i_wr) begin
      // Only defined field widths are stored, so reserved bits stay zero
      unique case (i_addr)
        sysclk_pkg::OFF_CLOCK_GATES:  st_d.cfg.gates    = i_wdata[7:0];
        sysclk_pkg::OFF_TX_DIV:       st_d.cfg.tx_div   = i_wdata[7:0];
        sysclk_pkg::OFF_RX_DIV:       st_d.cfg.rx_div   = i_wdata[7:0];
        sysclk_pkg::OFF_RX_SRC:       st_d.cfg.rx_src   = i_wdata[0];
        sysclk_pkg::OFF_CARD_DIV:     st_d.cfg.card_div = i_wdata[7:0];
        sysclk_pkg::OFF_DEBOUNCE_DIV: begin
          st_d.cfg.deb0_div = i_wdata[7:0];
          st_d.cfg.deb1_div = i_wdata[15:8];
          st_d.cfg.deb2_div = i_wdata[23:16];
        end
        sysclk_pkg::OFF_SPI_DIV: begin
          st_d.cfg.spi0_div = i_wdata[7:0];
          st_d.cfg.spi1_div = i_wdata[15:8];
          st_d.cfg.spi2_div = i_wdata[23:16];
        end
        sysclk_pkg::OFF_PROTECT:      st_d.cfg.protect   = i_wdata[15:0];
        sysclk_pkg::OFF_CONNECTOR:    st_d.cfg.connector = i_wdata[2:0];
        default:                      st_d.cfg = st_q.cfg;
      endcase
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      st_q                <= '0;
      st_q.cfg.gates      <= sysclk_pkg::GATES_RESET;
      st_q.cfg.tx_div     <= sysclk_pkg::DIV_RESET;
      st_q.cfg.rx_div     <= sysclk_pkg::DIV_RESET;
      st_q.cfg.card_div   <= sysclk_pkg::DIV_RESET;
      st_q.cfg.protect    <= sysclk_pkg::PROTECT_RESET;
      st_q.cfg.connector  <= sysclk_pkg::CONNECTOR_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign div_sel[0] = st_q.cfg.tx_div;
  assign div_sel[1] = st_q.cfg.rx_div;
  assign div_sel[2] = st_q.cfg.card_div;
  assign div_sel[3] = st_q.cfg.deb0_div;
  assign div_sel[4] = st_q.cfg.deb1_div;
  assign div_sel[5] = st_q.cfg.deb2_div;
  assign div_sel[6] = st_q.cfg.spi0_div;
  assign div_sel[7] = st_q.cfg.spi1_div;
  assign div_sel[8] = st_q.cfg.spi2_div;

  for (genvar g = 0; g < sysclk_pkg::DIV_COUNT; g++) begin : g_div
    clk_divider #(.W(sysclk_pkg::DIV_W)) u_div (
      .i_mclk    (i_mclk),
      .i_sys_rst (i_sys_rst),
      .i_div     (div_sel[g]),
      .o_tick    (ticks[g])
    );
  end

  // Gate bit order: 0 audio ref, 1 usb, 2 flash bus, 3 flash_controller,
  // 4 voltage_scaling_unit, 5 power_controller, 6 boot spi, 7 card
  assign o_clk_gate_en      = st_q.cfg.gates;
  assign o_tx_bitclk_tick   = ticks[sysclk_pkg::DIV_TX];
  assign o_rx_bitclk_tick   = st_q.cfg.rx_src ? ticks[sysclk_pkg::DIV_TX]
                                              : ticks[sysclk_pkg::DIV_RX];
  assign o_card_refclk_tick = ticks[sysclk_pkg::DIV_CARD];
  assign o_debounce_tick    = ticks[sysclk_pkg::DIV_DEB0 +: 3];
  assign o_spi_master_tick  = ticks[sysclk_pkg::DIV_SPI0 +: 3];
  assign o_protect_window   = st_q.cfg.protect;
  assign o_connector_gpio   = st_q.cfg.connector;
  assign o_rdata            = st_q.rdata;
  // lies with boot firmware reading the strap bit

  property p_gate_reset;
    @(posedge i_mclk) $fell(i_sys_rst) |-> o_clk_gate_en == 8'hFF;
  endproperty
  a_gate_reset: assert property (p_gate_reset) else $error("gates not enabled after reset");

  property p_gate_write;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_wr && i_addr == sysclk_pkg::OFF_CLOCK_GATES |=> o_clk_gate_en == $past(i_wdata[7:0]);
  endproperty
  a_gate_write: assert property (p_gate_write) else $error("gate write lost");

  property p_tx_div_one;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (st_q.cfg.tx_div <= 8'h01) [*3] |-> o_tx_bitclk_tick;
  endproperty
  a_tx_div_one: assert property (p_tx_div_one) else $error("divide-by-one missing");

  property p_rx_div_two;
    @(posedge i_mclk) disable iff (i_sys_rst)
      ticks[sysclk_pkg::DIV_RX] && $stable(st_q.cfg.rx_div) && st_q.cfg.rx_div == 8'h02
      |=> !ticks[sysclk_pkg::DIV_RX];
  endproperty
  a_rx_div_two: assert property (p_rx_div_two) else $error("receive divisor wrong");

  property p_rx_src;
    @(posedge i_mclk) disable iff (i_sys_rst)
      st_q.cfg.rx_src |-> o_rx_bitclk_tick == o_tx_bitclk_tick;
  endproperty
  a_rx_src: assert property (p_rx_src) else $error("receive source select wrong");

  property p_read_strap;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_rd && i_addr == sysclk_pkg::OFF_BOOT_IMAGE ##1 $stable(st_q.strap)
      |-> o_rdata == {30'h0, st_q.strap, 1'b0};
  endproperty
  a_read_strap: assert property (p_read_strap) else $error("strap read wrong");

  property p_protect_rw;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_wr && i_addr == sysclk_pkg::OFF_PROTECT ##1 i_rd && i_addr == sysclk_pkg::OFF_PROTECT
      |=> o_rdata == {16'h0000, $past(i_wdata[15:0], 2)};
  endproperty
  a_protect_rw: assert property (p_protect_rw) else $error("protect readback wrong");

  property p_reserved_zero;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_rd && i_addr == sysclk_pkg::OFF_DEBOUNCE_DIV |=> o_rdata[31:24] == 8'h00;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

  property p_connector;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_wr && i_addr == sysclk_pkg::OFF_CONNECTOR |=> o_connector_gpio == $past(i_wdata[2:0]);
  endproperty
  a_connector: assert property (p_connector) else $error("connector select wrong");

  property p_no_rd_idle;
    @(posedge i_mclk) disable iff (i_sys_rst) !i_rd |=> o_rdata == 32'h0000_0000;
  endproperty
  a_no_rd_idle: assert property (p_no_rd_idle) else $error("read data outside read slot");

  property p_card_div_one;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (st_q.cfg.card_div <= 8'h01) [*3] |-> o_card_refclk_tick;
  endproperty
  a_card_div_one: assert property (p_card_div_one) else $error("card divide-by-one missing");

  property p_debounce_one;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (st_q.cfg.deb0_div <= 8'h01 && st_q.cfg.deb1_div <= 8'h01 &&
       st_q.cfg.deb2_div <= 8'h01) [*3] |-> o_debounce_tick == 3'h7;
  endproperty
  a_debounce_one: assert property (p_debounce_one) else $error("debounce tick missing");

  property p_spi_one;
    @(posedge i_mclk) disable iff (i_sys_rst)
      (st_q.cfg.spi0_div <= 8'h01 && st_q.cfg.spi1_div <= 8'h01 &&
       st_q.cfg.spi2_div <= 8'h01) [*3] |-> o_spi_master_tick == 3'h7;
  endproperty
  a_spi_one: assert property (p_spi_one) else $error("SPI master tick missing");

  property p_gates_top_zero;
    @(posedge i_mclk) disable iff (i_sys_rst)
      i_rd && i_addr == sysclk_pkg::OFF_CLOCK_GATES |=> o_rdata[31:8] == 24'h00_0000;
  endproperty
  a_gates_top_zero: assert property (p_gates_top_zero) else $error("gate upper bits set");

  c_rx_from_tx: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_wr && i_addr == sysclk_pkg::OFF_RX_SRC && i_wdata[0]);
  c_spi_write: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_wr && i_addr == sysclk_pkg::OFF_SPI_DIV);
  c_gate_off: cover property (@(posedge i_mclk) disable iff (i_sys_rst) o_clk_gate_en == 8'h00);
  c_strap_read: cover property (@(posedge i_mclk) disable iff (i_sys_rst)
    i_rd && i_addr == sysclk_pkg::OFF_BOOT_IMAGE && st_q.strap);
endmodule

/* src/sysclk_pkg.sv */
/*
  Package for the system clock-control register block: register offsets,
  field positions, reset values and the carrier structs.
  Assumes a plain word-addressed register port with byte offsets.
*/
package sysclk_pkg;
  localparam int          ADDR_W             = 8;
  localparam int          DIV_W              = 8;
  localparam int          GATE_N             = 8;
  localparam logic [7:0]  OFF_CLOCK_GATES    = 8'h34;
  localparam logic [7:0]  OFF_TX_DIV         = 8'h40;
  localparam logic [7:0]  OFF_RX_DIV         = 8'h44;
  localparam logic [7:0]  OFF_RX_SRC         = 8'h48;
  localparam logic [7:0]  OFF_CARD_DIV       = 8'h4C;
  localparam logic [7:0]  OFF_DEBOUNCE_DIV   = 8'h50;
  localparam logic [7:0]  OFF_BOOT_IMAGE     = 8'h54;
  localparam logic [7:0]  OFF_PROTECT        = 8'h58;
  localparam logic [7:0]  OFF_SPI_DIV        = 8'h5C;
  localparam logic [7:0]  OFF_CONNECTOR      = 8'h70;
  localparam int          BOOT_IMAGE_BIT     = 1;
  localparam logic [7:0]  GATES_RESET        = 8'hFF;
  localparam logic [7:0]  DIV_RESET          = 8'h00;
  localparam logic [15:0] PROTECT_RESET      = 16'h0000;
  localparam logic [2:0]  CONNECTOR_RESET    = 3'h0;
  localparam int          DIV_COUNT          = 9;
  localparam int          DIV_TX             = 0;
  localparam int          DIV_RX             = 1;
  localparam int          DIV_CARD           = 2;
  localparam int          DIV_DEB0           = 3;
  localparam int          DIV_SPI0           = 6;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic              wr;
    logic              rd;
  } reg_req_t;

  typedef struct packed {
    logic [GATE_N-1:0] gates;
    logic [DIV_W-1:0]  tx_div;
    logic [DIV_W-1:0]  rx_div;
    logic              rx_src;
    logic [DIV_W-1:0]  card_div;
    logic [DIV_W-1:0]  deb0_div;
    logic [DIV_W-1:0]  deb1_div;
    logic [DIV_W-1:0]  deb2_div;
    logic [DIV_W-1:0]  spi0_div;
    logic [DIV_W-1:0]  spi1_div;
    logic [DIV_W-1:0]  spi2_div;
    logic [15:0]       protect;
    logic [2:0]        connector;
  } cfg_t;
endpackage

/* verif/tb_top.sv */
/*
  Self-checking bench for the clock-control register block: register
  reset values and access, divider periods, source select, strap and
  connector selects.
  Assumes the plain one-cycle register port and tick-enable dividers.
*/
`timescale 1ns/1ps
module tb_top;
  logic        i_mclk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic [7:0]  i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h00000000;
  logic        i_wr = 1'b0;
  logic        i_rd = 1'b0;
  logic        i_image_strap = 1'b0;
  logic [31:0] o_rdata;
  logic [7:0]  o_clk_gate_en;
  logic        o_tx_bitclk_tick;
  logic        o_rx_bitclk_tick;
  logic        o_card_refclk_tick;
  logic [2:0]  o_debounce_tick;
  logic [2:0]  o_spi_master_tick;
  logic [15:0] o_protect_window;
  logic [2:0]  o_connector_gpio;
  logic [8:0]  ticks;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          cyc = 0;

  // Tick order follows the package divider indices
  assign ticks = {o_spi_master_tick, o_debounce_tick, o_card_refclk_tick,
                  o_rx_bitclk_tick, o_tx_bitclk_tick};

  sys_clock_gate_divider_mux sys_clock_gate_divider_mux_inst (
    .i_mclk             (i_mclk),
    .i_sys_rst          (i_sys_rst),
    .i_addr             (i_addr),
    .i_wdata            (i_wdata),
    .i_wr               (i_wr),
    .i_rd               (i_rd),
    .i_image_strap      (i_image_strap),
    .o_rdata            (o_rdata),
    .o_clk_gate_en      (o_clk_gate_en),
    .o_tx_bitclk_tick   (o_tx_bitclk_tick),
    .o_rx_bitclk_tick   (o_rx_bitclk_tick),
    .o_card_refclk_tick (o_card_refclk_tick),
    .o_debounce_tick    (o_debounce_tick),
    .o_spi_master_tick  (o_spi_master_tick),
    .o_protect_window   (o_protect_window),
    .o_connector_gpio   (o_connector_gpio)
  );

  always #10 i_mclk = ~i_mclk;

  // Longest test path is under a thousand cycles; this ceiling leaves margin
  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      results();
    end
  end

  task automatic results();
    $display("checks %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_mclk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(name, exp, o_rdata);
  endtask

  // Cycles between two ticks; skips ticks left over from before a divisor change
  task automatic perchk(input string name, input int s, input logic [31:0] exp);
    logic [31:0] p;
    int          i;
    p = 32'h00000000;
    repeat (3) @(posedge i_mclk);
    #1;
    for (i = 0; i < 600 && ticks[s] !== 1'b1; i++) @(posedge i_mclk) #1;
    do begin
      @(posedge i_mclk) #1;
      p++;
    end while (ticks[s] !== 1'b1 && p < 600);
    chk(name, exp, p);
  endtask

  task automatic t_reset();
    int s;
    rdchk("gates", sysclk_pkg::OFF_CLOCK_GATES, 32'h000000FF);
    @(posedge i_mclk) #1 chk("rdata_idle", 32'h00000000, o_rdata);
    chk("gate_en", 32'h000000FF, {24'h000000, o_clk_gate_en});
    rdchk("tx", sysclk_pkg::OFF_TX_DIV, 32'h00000000);
    rdchk("rx", sysclk_pkg::OFF_RX_DIV, 32'h00000000);
    rdchk("src", sysclk_pkg::OFF_RX_SRC, 32'h00000000);
    rdchk("card", sysclk_pkg::OFF_CARD_DIV, 32'h00000000);
    rdchk("deb", sysclk_pkg::OFF_DEBOUNCE_DIV, 32'h00000000);
    rdchk("spi", sysclk_pkg::OFF_SPI_DIV, 32'h00000000);
    rdchk("prot", sysclk_pkg::OFF_PROTECT, 32'h00000000);
    rdchk("conn", sysclk_pkg::OFF_CONNECTOR, 32'h00000000);
    for (s = 0; s < 9; s++) perchk("reset_period", s, 32'h00000001);
    $display("test reset done");
  endtask

  task automatic t_gates();
    wr(sysclk_pkg::OFF_CLOCK_GATES, 32'hFFFFFF5A);
    rdchk("gates", sysclk_pkg::OFF_CLOCK_GATES, 32'h0000005A);
    chk("gate_en", 32'h0000005A, {24'h000000, o_clk_gate_en});
    wr(sysclk_pkg::OFF_CLOCK_GATES, 32'h000000A5);
    #1 chk("gate_en", 32'h000000A5, {24'h000000, o_clk_gate_en});
    $display("test gates done");
  endtask

  task automatic t_dividers();
    wr(sysclk_pkg::OFF_TX_DIV, 32'hFFFFFF03);
    rdchk("tx", sysclk_pkg::OFF_TX_DIV, 32'h00000003);
    perchk("tx_period", 0, 32'h00000003);
    wr(sysclk_pkg::OFF_TX_DIV, 32'h00000001);
    perchk("tx_one", 0, 32'h00000001);
    wr(sysclk_pkg::OFF_TX_DIV, 32'h000000FF);
    perchk("tx_max", 0, 32'h000000FF);
    wr(sysclk_pkg::OFF_RX_DIV, 32'h00000005);
    rdchk("rx", sysclk_pkg::OFF_RX_DIV, 32'h00000005);
    perchk("rx_period", 1, 32'h00000005);
    wr(sysclk_pkg::OFF_TX_DIV, 32'h00000007);
    wr(sysclk_pkg::OFF_RX_SRC, 32'hFFFFFFFF);
    rdchk("src", sysclk_pkg::OFF_RX_SRC, 32'h00000001);
    perchk("rx_from_tx", 1, 32'h00000007);
    wr(sysclk_pkg::OFF_RX_SRC, 32'h00000000);
    perchk("rx_own", 1, 32'h00000005);
    wr(sysclk_pkg::OFF_CARD_DIV, 32'h00000002);
    rdchk("card", sysclk_pkg::OFF_CARD_DIV, 32'h00000002);
    perchk("card_period", 2, 32'h00000002);
    wr(sysclk_pkg::OFF_DEBOUNCE_DIV, 32'hFF040302);
    rdchk("deb", sysclk_pkg::OFF_DEBOUNCE_DIV, 32'h00040302);
    perchk("deb0", 3, 32'h00000002);
    perchk("deb1", 4, 32'h00000003);
    perchk("deb2", 5, 32'h00000004);
    wr(sysclk_pkg::OFF_SPI_DIV, 32'hFF060504);
    rdchk("spi", sysclk_pkg::OFF_SPI_DIV, 32'h00060504);
    perchk("spi0", 6, 32'h00000004);
    perchk("spi1", 7, 32'h00000005);
    perchk("spi2", 8, 32'h00000006);
    $display("test dividers done");
  endtask

  task automatic t_misc();
    @(posedge i_mclk);
    i_image_strap <= 1'b1;
    repeat (2) @(posedge i_mclk);
    rdchk("strap_hi", sysclk_pkg::OFF_BOOT_IMAGE, 32'h00000002);
    wr(sysclk_pkg::OFF_BOOT_IMAGE, 32'h00000000);
    rdchk("strap_ro", sysclk_pkg::OFF_BOOT_IMAGE, 32'h00000002);
    @(posedge i_mclk);
    i_image_strap <= 1'b0;
    repeat (2) @(posedge i_mclk);
    // Zero here is what boot firmware takes as stay halted
    rdchk("strap_lo", sysclk_pkg::OFF_BOOT_IMAGE, 32'h00000000);
    wr(sysclk_pkg::OFF_PROTECT, 32'hFFFFABCD);
    rdchk("prot", sysclk_pkg::OFF_PROTECT, 32'h0000ABCD);
    chk("prot_out", 32'h0000ABCD, {16'h0000, o_protect_window});
    wr(sysclk_pkg::OFF_CONNECTOR, 32'hFFFFFFFD);
    rdchk("conn", sysclk_pkg::OFF_CONNECTOR, 32'h00000005);
    chk("conn_out", 32'h00000005, {29'h00000000, o_connector_gpio});
    wr(8'h60, 32'hFFFFFFFF);
    rdchk("unmapped", 8'h60, 32'h00000000);
    rdchk("gates_kept", sysclk_pkg::OFF_CLOCK_GATES, 32'h000000A5);
    $display("test misc done");
  endtask

  initial begin
    repeat (12) @(posedge i_mclk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_gates();
    t_dividers();
    t_misc();
    results();
  end
endmodule
